// File: logic/hut_pkg.sv
// shared constants and types of the serial transport, both ends
// assumes one 250 MHz reference clock on each end
package hut_pkg;

  // ----------------------------------------
  // clock and line rate
  // ----------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_DEFAULT = 57_600;
  localparam int DIV_W = 20;
  localparam logic [DIV_W-1:0] DEF_DIV = DIV_W'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [DIV_W-1:0] MIN_DIV = 20'h00004;

  // ----------------------------------------
  // character framing
  // ----------------------------------------
  localparam int DATA_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int FRAME_BITS = 10;
  localparam logic IDLE_LVL = 1'b1;
  localparam logic START_LVL = 1'b0;

  // ----------------------------------------
  // buffering and flow control
  // ----------------------------------------
  localparam int FIFO_DEPTH = 128;
  localparam int FLOW_OFF_US = 3000;
  // characters a far end may still land after flow-off at the default rate
  localparam int RTS_MARGIN = (FLOW_OFF_US * BAUD_DEFAULT) / (FRAME_BITS * 1_000_000);

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} hut_state_e;

endpackage : hut_pkg

// File: logic/hut_link_if.sv
// crossed four-wire serial link between device end and host end
// assumes the bench instantiates it once and connects both ends
`timescale 1ns/10ps
interface hut_link_if;
  logic dev_txd;
  logic dev_rts;
  logic host_txd;
  logic host_rts;

  // each end sees the far txd as rxd and the far rts as cts
  modport dev (
    output dev_txd,
    output dev_rts,
    input host_txd,
    input host_rts
  );
  modport host (
    output host_txd,
    output host_rts,
    input dev_txd,
    input dev_rts
  );
endinterface : hut_link_if

// File: logic/hut_dev_end.sv
// device end of the transport: uart with 128-byte tx and rx fifos
// assumes ref_clk at 250 MHz, link pins from hut_link_if.dev
//
// Contract
// [R1] baud configurable, default 57.6 kbit/s after reset
// [R2] every character carries eight data bits
// [R3] no parity, single stop bit
// [R4] rts/cts only guards receive buffer overrun
// [R5] far transmitter stops within 3 ms
// [R6] start a character only while cts high
// [R7] no new character while cts low
// [R8] txd to far rxd, rts to far cts
// [R9] line assumed error free, no recovery
// [R10] separate 128-byte transmit and receive fifos
// [R11] rxd txd cts rts on dedicated pins
// [R12] low start bit, data lsb first
`timescale 1ns/10ps
module hut_dev_end #(
  parameter logic [hut_pkg::DIV_W-1:0] BAUD_DIV = hut_pkg::DEF_DIV,
  parameter int DEPTH = hut_pkg::FIFO_DEPTH,
  parameter int RTS_MARGIN = hut_pkg::RTS_MARGIN
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  hut_link_if.dev link,
  input wire logic cfg_div_load,
  input wire logic [hut_pkg::DIV_W-1:0] cfg_div,
  input wire logic tx_valid,
  input wire logic [hut_pkg::DATA_BITS-1:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [hut_pkg::DATA_BITS-1:0] rx_data,
  input wire logic rx_ready
);

  // ----------------------------------------
  // local sizes
  // ----------------------------------------
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_RTS_OFF = CNT_W'(DEPTH - RTS_MARGIN);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [hut_pkg::DIV_W-1:0] baud_div;
  logic [2:0] sy_rxd;
  logic [2:0] sy_cts;
  logic rxd_f;
  logic cts_f;
  logic txd;
  logic rts;

  // ----------------------------------------
  // rate register
  // ----------------------------------------
  // reload ignored below the least usable divisor
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_div <= BAUD_DIV; // [R1]
    end else if (cfg_div_load && (cfg_div >= hut_pkg::MIN_DIV)) begin
      baud_div <= cfg_div; // [R1]
    end
  end

  // ----------------------------------------
  // pin input filters
  // ----------------------------------------
  // three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy_rxd <= {3{hut_pkg::IDLE_LVL}};
      sy_cts <= 3'h0;
      rxd_f <= hut_pkg::IDLE_LVL;
      cts_f <= 1'b0;
    end else begin
      sy_rxd <= {sy_rxd[1:0], link.host_txd}; // [R8] [R11]
      sy_cts <= {sy_cts[1:0], link.host_rts}; // [R8] [R11]
      if (sy_rxd[1] == sy_rxd[2]) begin
        rxd_f <= sy_rxd[2];
      end
      if (sy_cts[1] == sy_cts[2]) begin
        cts_f <= sy_cts[2];
      end
    end
  end

  // ----------------------------------------
  // transmit fifo
  // ----------------------------------------
  logic [hut_pkg::DATA_BITS-1:0] tx_mem [DEPTH];
  logic [PTR_W-1:0] tx_wr;
  logic [PTR_W-1:0] tx_rd;
  logic [CNT_W-1:0] tx_count;
  hut_pkg::hut_state_e tx_state;
  logic [hut_pkg::DIV_W-1:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [hut_pkg::DATA_BITS-1:0] tx_shift;

  // push from user, pop only when idle and cts high
  wire tx_push = tx_valid && tx_ready;
  wire tx_pop = (tx_state == hut_pkg::ST_IDLE) && (tx_count != '0) && cts_f; // [R6] [R7]
  wire [CNT_W-1:0] next_tx_count = tx_count + (tx_push ? CNT_ONE : '0) - (tx_pop ? CNT_ONE : '0);

  always_ff @(posedge ref_clk) begin
    if (tx_push) begin
      tx_mem[tx_wr] <= tx_data; // [R10]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_wr <= '0;
      tx_rd <= '0;
      tx_count <= '0;
      tx_ready <= 1'b0;
    end else begin
      tx_wr <= tx_wr + (tx_push ? PTR_W'(1) : '0);
      tx_rd <= tx_rd + (tx_pop ? PTR_W'(1) : '0);
      tx_count <= next_tx_count;
      tx_ready <= next_tx_count != CNT_FULL; // [R10]
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  wire tx_tick = (tx_cnt == baud_div - 1'b1);

  // bit timer, held at zero while idle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt <= '0;
    end else begin
      tx_cnt <= ((tx_state == hut_pkg::ST_IDLE) || tx_tick) ? '0 : tx_cnt + 1'b1;
    end
  end

  // start, eight data bits lsb first, one stop bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= hut_pkg::ST_IDLE;
      tx_bit <= 3'h0;
      tx_shift <= '0;
      txd <= hut_pkg::IDLE_LVL;
    end else begin
      case (tx_state)
        hut_pkg::ST_IDLE: begin
          txd <= hut_pkg::IDLE_LVL;
          if (tx_pop) begin
            tx_shift <= tx_mem[tx_rd];
            txd <= hut_pkg::START_LVL; // [R12]
            tx_state <= hut_pkg::ST_START;
          end
        end
        hut_pkg::ST_START: begin
          if (tx_tick) begin
            txd <= tx_shift[0]; // [R12]
            tx_bit <= 3'h0;
            tx_state <= hut_pkg::ST_DATA;
          end
        end
        hut_pkg::ST_DATA: begin
          if (tx_tick) begin
            if (tx_bit == hut_pkg::LAST_BIT) begin
              txd <= hut_pkg::IDLE_LVL; // [R3]
              tx_state <= hut_pkg::ST_STOP;
            end else begin
              txd <= tx_shift[1]; // [R2]
              tx_shift <= tx_shift >> 1;
              tx_bit <= tx_bit + 3'h1;
            end
          end
        end
        default: begin
          // one stop bit, then cts is looked at again
          if (tx_tick) begin
            tx_state <= hut_pkg::ST_IDLE; // [R3] [R5]
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  hut_pkg::hut_state_e rx_state;
  logic [hut_pkg::DIV_W-1:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [hut_pkg::DATA_BITS-1:0] rx_shift;

  wire rx_tick = (rx_cnt == baud_div - 1'b1);
  wire rx_half = (rx_cnt == (baud_div >> 1));
  wire rx_clr = (rx_state == hut_pkg::ST_IDLE) || rx_tick ||
                ((rx_state == hut_pkg::ST_START) && rx_half);
  // character kept only with a high stop bit, no recovery otherwise
  wire rx_done = (rx_state == hut_pkg::ST_STOP) && rx_tick &&
                 (rxd_f == hut_pkg::IDLE_LVL); // [R3] [R9]

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt <= '0;
    end else begin
      rx_cnt <= rx_clr ? '0 : rx_cnt + 1'b1;
    end
  end

  // start edge, mid-bit check, then sample at bit centres
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= hut_pkg::ST_IDLE;
      rx_bit <= 3'h0;
      rx_shift <= '0;
    end else begin
      case (rx_state)
        hut_pkg::ST_IDLE: begin
          if (rxd_f == hut_pkg::START_LVL) begin
            rx_state <= hut_pkg::ST_START; // [R12]
          end
        end
        hut_pkg::ST_START: begin
          if (rx_half) begin
            rx_bit <= 3'h0;
            rx_state <= (rxd_f == hut_pkg::START_LVL) ? hut_pkg::ST_DATA : hut_pkg::ST_IDLE;
          end
        end
        hut_pkg::ST_DATA: begin
          if (rx_tick) begin
            rx_shift <= {rxd_f, rx_shift[hut_pkg::DATA_BITS-1:1]}; // [R2] [R12]
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == hut_pkg::LAST_BIT) begin
              rx_state <= hut_pkg::ST_STOP;
            end
          end
        end
        default: begin
          if (rx_tick) begin
            rx_state <= hut_pkg::ST_IDLE; // [R3]
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive fifo and output stage
  // ----------------------------------------
  logic [hut_pkg::DATA_BITS-1:0] rx_mem [DEPTH];
  logic [PTR_W-1:0] rx_wr;
  logic [PTR_W-1:0] rx_rd;
  logic [CNT_W-1:0] rx_count;

  // a character that meets a full fifo is dropped
  wire rx_push = rx_done && (rx_count != CNT_FULL);
  wire rx_load = (rx_count != '0) && (!rx_valid || rx_ready);
  wire [CNT_W-1:0] next_rx_count = rx_count + (rx_push ? CNT_ONE : '0) - (rx_load ? CNT_ONE : '0);

  always_ff @(posedge ref_clk) begin
    if (rx_push) begin
      rx_mem[rx_wr] <= rx_shift; // [R10]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_wr <= '0;
      rx_rd <= '0;
      rx_count <= '0;
    end else begin
      rx_wr <= rx_wr + (rx_push ? PTR_W'(1) : '0);
      rx_rd <= rx_rd + (rx_load ? PTR_W'(1) : '0);
      rx_count <= next_rx_count;
    end
  end

  // output register, refilled when empty or taken
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else if (rx_load) begin
      rx_valid <= 1'b1;
      rx_data <= rx_mem[rx_rd];
    end else if (rx_ready) begin
      rx_valid <= 1'b0;
    end
  end

  // rts drops with room left for what arrives during flow-off
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rts <= 1'b0;
    end else begin
      rts <= next_rx_count < CNT_RTS_OFF; // [R4] [R5]
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign link.dev_txd = txd; // [R8] [R11]
  assign link.dev_rts = rts; // [R8] [R11]

endmodule : hut_dev_end

// File: logic/hut_host_end.sv
// host end of the transport: uart with one holding byte each way
// assumes ref_clk at 250 MHz, link pins from hut_link_if.host
`timescale 1ns/10ps
module hut_host_end #(
  parameter logic [hut_pkg::DIV_W-1:0] BAUD_DIV = hut_pkg::DEF_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  hut_link_if.host link,
  input wire logic cfg_div_load,
  input wire logic [hut_pkg::DIV_W-1:0] cfg_div,
  input wire logic tx_valid,
  input wire logic [hut_pkg::DATA_BITS-1:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [hut_pkg::DATA_BITS-1:0] rx_data,
  input wire logic rx_allow
);

  logic [hut_pkg::DIV_W-1:0] baud_div;
  logic [2:0] sy_rxd;
  logic [2:0] sy_cts;
  logic rxd_f;
  logic cts_f;
  logic txd;
  logic rts;
  logic tx_full;
  logic [hut_pkg::DATA_BITS-1:0] tx_hold;
  hut_pkg::hut_state_e tx_state;
  logic [hut_pkg::DIV_W-1:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [hut_pkg::DATA_BITS-1:0] tx_shift;
  hut_pkg::hut_state_e rx_state;
  logic [hut_pkg::DIV_W-1:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [hut_pkg::DATA_BITS-1:0] rx_shift;

  // ----------------------------------------
  // rate, filters, rts
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_div <= BAUD_DIV; // [R1]
      sy_rxd <= {3{hut_pkg::IDLE_LVL}};
      sy_cts <= 3'h0;
      rxd_f <= hut_pkg::IDLE_LVL;
      cts_f <= 1'b0;
      rts <= 1'b0;
    end else begin
      if (cfg_div_load && (cfg_div >= hut_pkg::MIN_DIV)) begin
        baud_div <= cfg_div; // [R1]
      end
      sy_rxd <= {sy_rxd[1:0], link.dev_txd}; // [R8]
      sy_cts <= {sy_cts[1:0], link.dev_rts}; // [R8]
      if (sy_rxd[1] == sy_rxd[2]) begin
        rxd_f <= sy_rxd[2];
      end
      if (sy_cts[1] == sy_cts[2]) begin
        cts_f <= sy_cts[2];
      end
      rts <= rx_allow; // [R4]
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  wire tx_tick = (tx_cnt == baud_div - 1'b1);
  wire tx_start = (tx_state == hut_pkg::ST_IDLE) && tx_full && cts_f; // [R6] [R7]
  wire tx_take = tx_valid && tx_ready;

  // one holding byte, ready drops while it is full
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_full <= 1'b0;
      tx_hold <= '0;
      tx_ready <= 1'b0;
      tx_cnt <= '0;
    end else begin
      if (tx_take) begin
        tx_hold <= tx_data;
      end
      tx_full <= tx_take || (tx_full && !tx_start);
      tx_ready <= !(tx_take || (tx_full && !tx_start));
      tx_cnt <= ((tx_state == hut_pkg::ST_IDLE) || tx_tick) ? '0 : tx_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= hut_pkg::ST_IDLE;
      tx_bit <= 3'h0;
      tx_shift <= '0;
      txd <= hut_pkg::IDLE_LVL;
    end else begin
      case (tx_state)
        hut_pkg::ST_IDLE: begin
          txd <= hut_pkg::IDLE_LVL;
          if (tx_start) begin
            tx_shift <= tx_hold;
            txd <= hut_pkg::START_LVL; // [R12]
            tx_state <= hut_pkg::ST_START;
          end
        end
        hut_pkg::ST_START: begin
          if (tx_tick) begin
            txd <= tx_shift[0]; // [R12]
            tx_bit <= 3'h0;
            tx_state <= hut_pkg::ST_DATA;
          end
        end
        hut_pkg::ST_DATA: begin
          if (tx_tick) begin
            if (tx_bit == hut_pkg::LAST_BIT) begin
              txd <= hut_pkg::IDLE_LVL; // [R3]
              tx_state <= hut_pkg::ST_STOP;
            end else begin
              txd <= tx_shift[1]; // [R2]
              tx_shift <= tx_shift >> 1;
              tx_bit <= tx_bit + 3'h1;
            end
          end
        end
        default: begin
          if (tx_tick) begin
            tx_state <= hut_pkg::ST_IDLE; // [R5]
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  wire rx_tick = (rx_cnt == baud_div - 1'b1);
  wire rx_half = (rx_cnt == (baud_div >> 1));
  wire rx_clr = (rx_state == hut_pkg::ST_IDLE) || rx_tick ||
                ((rx_state == hut_pkg::ST_START) && rx_half);
  wire rx_done = (rx_state == hut_pkg::ST_STOP) && rx_tick &&
                 (rxd_f == hut_pkg::IDLE_LVL); // [R3] [R9]

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt <= '0;
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_cnt <= rx_clr ? '0 : rx_cnt + 1'b1;
      rx_valid <= rx_done;
      if (rx_done) begin
        rx_data <= rx_shift;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= hut_pkg::ST_IDLE;
      rx_bit <= 3'h0;
      rx_shift <= '0;
    end else begin
      case (rx_state)
        hut_pkg::ST_IDLE: begin
          if (rxd_f == hut_pkg::START_LVL) begin
            rx_state <= hut_pkg::ST_START; // [R12]
          end
        end
        hut_pkg::ST_START: begin
          if (rx_half) begin
            rx_bit <= 3'h0;
            rx_state <= (rxd_f == hut_pkg::START_LVL) ? hut_pkg::ST_DATA : hut_pkg::ST_IDLE;
          end
        end
        hut_pkg::ST_DATA: begin
          if (rx_tick) begin
            rx_shift <= {rxd_f, rx_shift[hut_pkg::DATA_BITS-1:1]}; // [R2] [R12]
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == hut_pkg::LAST_BIT) begin
              rx_state <= hut_pkg::ST_STOP;
            end
          end
        end
        default: begin
          if (rx_tick) begin
            rx_state <= hut_pkg::ST_IDLE; // [R3]
          end
        end
      endcase
    end
  end

  assign link.host_txd = txd; // [R8]
  assign link.host_rts = rts; // [R8]

endmodule : hut_host_end

// File: sim/hut_link_assertions.sv
// checker of the crossed serial link: start, stop and flow-off timing
// assumes both ends run at DIV clocks per bit from one ref_clk
`timescale 1ns/10ps
module hut_link_assertions #(
  parameter int DIV = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic dev_txd,
  input wire logic dev_rts,
  input wire logic host_txd,
  input wire logic host_rts
);
  localparam int STOP_AT = 9 * DIV + DIV / 2;
  localparam int FRAME = 10 * DIV;
  localparam int FLOW_N = FRAME + 8;
  logic [1:0] txd;
  logic [1:0] cts;
  logic [1:0] prev;
  logic [1:0] st;
  logic [15:0] fcnt [2];
  logic [15:0] lcnt [2];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // frame and flow-off tracking, index 0 device, 1 host
  // ----------------------------------------
  assign txd = {host_txd, dev_txd};
  assign cts = {dev_rts, host_rts};
  assign st[0] = (fcnt[0] == 16'h0000) && prev[0] && !txd[0];
  assign st[1] = (fcnt[1] == 16'h0000) && prev[1] && !txd[1];

  // frame counter from each start, cycles of far rts low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 2'h3;
      fcnt <= '{default: 16'h0000};
      lcnt <= '{default: 16'h0000};
    end else begin
      for (int i = 0; i < 2; i++) begin
        prev[i] <= txd[i];
        if (st[i]) begin
          fcnt[i] <= 16'h0001;
        end else if (fcnt[i] != 16'h0000) begin
          fcnt[i] <= (fcnt[i] == 16'(FRAME - 1)) ? 16'h0000 : fcnt[i] + 16'h0001;
        end
        if (cts[i]) begin
          lcnt[i] <= 16'h0000;
        end else if (lcnt[i] != 16'(FLOW_N)) begin
          lcnt[i] <= lcnt[i] + 16'h0001;
        end
      end
    end
  end

  property p_stop(logic s, logic t);
    s |-> ##STOP_AT t;
  endproperty

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_dev_start_low: assert property (st[0] |-> !dev_txd [*8])
    else $error("device start bit shorter than half a bit");
  a_host_start_low: assert property (st[1] |-> !host_txd [*8])
    else $error("host start bit shorter than half a bit");
  a_dev_stop_bit: assert property (p_stop(st[0], dev_txd))
    else $error("device stop bit not high after eight data bits");
  a_host_stop_bit: assert property (p_stop(st[1], host_txd))
    else $error("host stop bit not high after eight data bits");
  a_dev_start_cts: assert property (st[0] |-> lcnt[0] < 16'h0008)
    else $error("device started a character with cts low");
  a_host_start_cts: assert property (st[1] |-> lcnt[1] < 16'h0008)
    else $error("host started a character with cts low");
  a_dev_flow_off: assert property (lcnt[0] == 16'(FLOW_N) |-> dev_txd)
    else $error("device byte flow not stopped after flow-off");
  a_host_flow_off: assert property (lcnt[1] == 16'(FLOW_N) |-> host_txd)
    else $error("host byte flow not stopped after flow-off");

  c_dev_frame: cover property (st[0]);
  c_host_frame: cover property (st[1]);
  c_dev_held_off: cover property (lcnt[0] == 16'(FLOW_N));
  c_host_held_off: cover property (lcnt[1] == 16'(FLOW_N));
endmodule : hut_link_assertions

// File: sim/tb_hci_uart_transport.sv
// self-checking bench: device end and host end joined by the link
// assumes both ends loaded to 16 clocks per bit after reset, queues model each direction
`timescale 1ns/10ps
module tb_hci_uart_transport;
  localparam int DIV = 16;
  localparam int FRAME = 10 * DIV;
  localparam logic [hut_pkg::DIV_W-1:0] DIV_P = 20'h00010;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cfg_load = 1'b0;
  logic [hut_pkg::DIV_W-1:0] cfg_div = DIV_P;
  logic d_tx_valid = 1'b0, h_tx_valid = 1'b0, d_rx_ready = 1'b0, h_rx_allow = 1'b1;
  logic [7:0] d_tx_data = 8'h00, h_tx_data = 8'h00;
  logic d_tx_ready, d_rx_valid, h_tx_ready, h_rx_valid;
  logic [7:0] d_rx_data, h_rx_data;
  logic [1:0] rdy_mode = 2'h0;
  int error_cnt = 0, samples_checked = 0, cyc = 0, h_rx_cnt = 0;
  logic [7:0] to_host[$], to_dev[$];

  hut_link_if link ();

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  // both ends start at the default rate and are loaded to DIV_P before traffic
  hut_dev_end u_hut_dev_end (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(link.dev), .cfg_div_load(cfg_load), .cfg_div(cfg_div), .tx_valid(d_tx_valid),
    .tx_data(d_tx_data), .tx_ready(d_tx_ready), .rx_valid(d_rx_valid),
    .rx_data(d_rx_data), .rx_ready(d_rx_ready));
  hut_host_end u_hut_host_end (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(link.host), .cfg_div_load(cfg_load), .cfg_div(cfg_div), .tx_valid(h_tx_valid),
    .tx_data(h_tx_data), .tx_ready(h_tx_ready), .rx_valid(h_rx_valid),
    .rx_data(h_rx_data), .rx_allow(h_rx_allow));
  hut_link_assertions #(.DIV(DIV)) u_hut_link_assertions (.ref_clk(ref_clk), .rst_b(rst_b),
    .dev_txd(link.dev_txd), .dev_rts(link.dev_rts), .host_txd(link.host_txd),
    .host_rts(link.host_rts));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // one byte offered to either end, held until taken
  task automatic send(input bit host, input logic [7:0] b);
    @(posedge ref_clk);
    #1;
    if (host) {h_tx_valid, h_tx_data} = {1'b1, b};
    else {d_tx_valid, d_tx_data} = {1'b1, b};
    do @(posedge ref_clk); while ((host ? h_tx_ready : d_tx_ready) !== 1'b1);
    if (host) to_dev.push_back(b);
    else to_host.push_back(b);
    #1;
    if (host) h_tx_valid = 1'b0;
    else d_tx_valid = 1'b0;
  endtask : send

  // samples one device frame at mid-bit
  task automatic wire_chk(input logic [7:0] b);
    logic [9:0] seen;
    while (link.dev_txd !== 1'b0) @(posedge ref_clk);
    repeat (DIV / 2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      seen[i] = link.dev_txd;
      repeat (DIV) @(posedge ref_clk);
    end
    check("wire_data", b, seen[8:1]);
    check("wire_ends", 8'h02, {6'h00, seen[9], seen[0]});
  endtask : wire_chk

  task automatic drain();
    while (to_host.size() + to_dev.size() != 0) @(posedge ref_clk);
    repeat (FRAME) @(posedge ref_clk);
  endtask : drain

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // receive monitors against the queue model, timeout
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      end_of_test();
    end
    if (rst_b === 1'b1 && h_rx_valid === 1'b1) begin
      h_rx_cnt++;
      check("host_rx", to_host.size() > 0 ? to_host.pop_front() : 8'hxx, h_rx_data);
    end
    if (rst_b === 1'b1 && d_rx_valid === 1'b1 && d_rx_ready === 1'b1) begin
      check("dev_rx", to_dev.size() > 0 ? to_dev.pop_front() : 8'hxx, d_rx_data);
    end
    #1 d_rx_ready = (rdy_mode == 2'h2) ? 1'($urandom_range(0, 1)) : rdy_mode[0];
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    int k;
    int idle;
    void'($urandom(26302));
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    // rate change on both ends, then a divisor below the least one is ignored
    @(posedge ref_clk);
    #1 cfg_load = 1'b1;
    @(posedge ref_clk);
    #1 cfg_div = 20'h00003;
    @(posedge ref_clk);
    #1 cfg_load = 1'b0;
    cfg_div = DIV_P;
    repeat (4) @(posedge ref_clk);
    check("idle_lines", 8'h03, {6'h00, link.dev_txd, link.host_txd});
    // wire format, then both directions at once with a random reader
    rdy_mode = 2'h2;
    fork
      send(1'b0, 8'hb4);
      wire_chk(8'hb4);
    join
    fork
      for (int i = 0; i < 12; i++) send(1'b0, i == 0 ? 8'h00 : (i == 1 ? 8'hff : 8'($urandom)));
      for (int i = 0; i < 12; i++) send(1'b1, i == 0 ? 8'hff : (i == 1 ? 8'h00 : 8'($urandom)));
    join
    drain();
    // host holds off, device fifo fills until refused
    @(posedge ref_clk);
    #1 h_rx_allow = 1'b0;
    repeat (10) @(posedge ref_clk);
    n = h_rx_cnt;
    k = 0;
    idle = 0;
    #1 d_tx_valid = 1'b1;
    while (idle < 20) begin
      d_tx_data = 8'($urandom);
      @(posedge ref_clk);
      if (d_tx_ready === 1'b1) begin
        to_host.push_back(d_tx_data);
        k++;
        idle = 0;
      end else begin
        idle++;
      end
      #1;
    end
    d_tx_valid = 1'b0;
    check("tx_fifo_fill", 8'(hut_pkg::FIFO_DEPTH), 8'(k));
    repeat (3 * FRAME) @(posedge ref_clk);
    check("flow_off", 8'(n), 8'(h_rx_cnt));
    #1 h_rx_allow = 1'b1;
    drain();
    // device reader stalls, its rts must hold the host off without loss
    rdy_mode = 2'h0;
    fork
      for (int i = 0; i < 120; i++) send(1'b1, 8'(i));
      begin
        while (to_dev.size() < 113) @(posedge ref_clk);
        repeat (3 * FRAME) @(posedge ref_clk);
        check("dev_rts_low", 8'h00, {7'h00, link.dev_rts});
        n = to_dev.size();
        repeat (2 * FRAME) @(posedge ref_clk);
        check("host_held", 8'(n), 8'(to_dev.size()));
        rdy_mode = 2'h1;
      end
    join
    drain();
    check("dev_rts_high", 8'h01, {7'h00, link.dev_rts});
    end_of_test();
  end
endmodule : tb_hci_uart_transport
